/* File: hdl/kms_host.sv */
`timescale 1ns/1ps
module kms_host #(
    parameter int DISP_LEN = kms_pkg::DISP_BITS
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // host parallel port pins
    input wire logic [7:0] in_port_i,
    output logic [7:0] out_port_o,
    // key events to the user
    output kms_pkg::kms_key_event_t key_event_o,
    output logic key_any_o,
    // display load request
    input wire logic disp_start_i,
    input wire logic [DISP_LEN-1:0] disp_pattern_i,
    output logic disp_busy_o
);
    // a one-bit pattern has no shift path to slice
    // and more than 1024 bits is refused, though the 11-bit bit counter would hold up to 2047
    if (DISP_LEN < 2 || DISP_LEN > 1024) begin : g_len_check
        $error("kms_host: DISP_LEN out of range");
    end

    typedef enum {
        KMS_ALL,
        KMS_ALL_WAIT,
        KMS_COL,
        KMS_COL_WAIT,
        KMS_RELEASE
    } kms_scan_t;

    typedef enum {
        KMS_D_IDLE,
        KMS_D_LOW,
        KMS_D_HIGH
    } kms_disp_t;

    logic [5:0] row_meta_reg;
    logic [5:0] row_sync_reg;
    kms_scan_t scan_reg;
    logic [1:0] col_reg;
    logic [3:0] col_drive_reg;
    logic [7:0] settle_reg;
    kms_pkg::kms_key_event_t event_reg;
    logic any_reg;
    kms_disp_t disp_reg;
    logic [DISP_LEN-1:0] shift_reg;
    logic [10:0] bits_left_reg;
    logic [7:0] half_reg;
    logic disp_clk_reg;
    logic disp_data_reg;
    logic [5:0] row_low;
    logic [2:0] row_idx;

    // rows come from pins: two flops before use
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            row_meta_reg <= 6'h3F;
            row_sync_reg <= 6'h3F;
        end else begin
            row_meta_reg <= in_port_i[5:0];
            row_sync_reg <= row_meta_reg;
        end
    end

    assign row_low = ~row_sync_reg;

    always_comb begin
        row_idx = 3'h0;
        for (int i = kms_pkg::NUM_ROWS - 1; i >= 0; i--) begin
            if (row_low[i]) begin
                row_idx = 3'(i);
            end
        end
    end

    // scanner: detect with all columns low, then identify column by column
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            scan_reg <= KMS_ALL;
            col_reg <= 2'h0;
            col_drive_reg <= kms_pkg::COLS_IDLE;
            settle_reg <= 8'h00;
            event_reg <= '0;
            any_reg <= 1'b0;
        end else begin
            event_reg.valid <= 1'b0;
            case (scan_reg)
                KMS_ALL: begin
                    col_drive_reg <= kms_pkg::COLS_ALL;
                    settle_reg <= 8'(kms_pkg::SETTLE_CYC);
                    scan_reg <= KMS_ALL_WAIT;
                end
                KMS_ALL_WAIT: begin
                    if (settle_reg != 8'h00) begin
                        settle_reg <= settle_reg - 8'h01;
                    end else if (row_low != 6'h00) begin
                        any_reg <= 1'b1;
                        col_reg <= 2'h0;
                        // only one column low, rest high
                        col_drive_reg <= ~4'h1;
                        settle_reg <= 8'(kms_pkg::SETTLE_CYC);
                        scan_reg <= KMS_COL_WAIT;
                    end else begin
                        any_reg <= 1'b0;
                    end
                end
                KMS_COL_WAIT: begin
                    if (settle_reg != 8'h00) begin
                        settle_reg <= settle_reg - 8'h01;
                    end else begin
                        scan_reg <= KMS_COL;
                    end
                end
                KMS_COL: begin
                    // diodes keep other columns out of this reading
                    if (row_low != 6'h00) begin
                        event_reg.valid <= 1'b1;
                        event_reg.key.row <= 6'(row_idx);
                        event_reg.key.col <= col_reg;
                        col_drive_reg <= kms_pkg::COLS_ALL;
                        settle_reg <= 8'(kms_pkg::SETTLE_CYC);
                        scan_reg <= KMS_RELEASE;
                    end else if (col_reg == 2'(kms_pkg::NUM_COLS - 1)) begin
                        // bounce: press vanished before identification
                        scan_reg <= KMS_ALL;
                    end else begin
                        col_reg <= col_reg + 2'h1;
                        col_drive_reg <= ~(4'h1 << (col_reg + 2'h1));
                        settle_reg <= 8'(kms_pkg::SETTLE_CYC);
                        scan_reg <= KMS_COL_WAIT;
                    end
                end
                KMS_RELEASE: begin
                    // one event per press: wait until every key is open
                    if (settle_reg != 8'h00) begin
                        settle_reg <= settle_reg - 8'h01;
                    end else if (row_low == 6'h00) begin
                        any_reg <= 1'b0;
                        scan_reg <= KMS_ALL;
                    end
                end
                default: scan_reg <= KMS_ALL;
            endcase
        end
    end

    // display shifter: data changes with clock low, captured on rise
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            disp_reg <= KMS_D_IDLE;
            shift_reg <= '1;
            bits_left_reg <= 11'h000;
            half_reg <= 8'h00;
            disp_clk_reg <= 1'b0;
            disp_data_reg <= 1'b1;
        end else begin
            case (disp_reg)
                KMS_D_IDLE: begin
                    disp_clk_reg <= 1'b0;
                    if (disp_start_i) begin
                        shift_reg <= disp_pattern_i;
                        bits_left_reg <= 11'(DISP_LEN);
                        disp_reg <= KMS_D_LOW;
                        half_reg <= 8'h00;
                    end
                end
                KMS_D_LOW: begin
                    if (half_reg == 8'h00) begin
                        disp_data_reg <= shift_reg[DISP_LEN-1];
                    end
                    if (half_reg == 8'(kms_pkg::DISP_HALF_CYC)) begin
                        disp_clk_reg <= 1'b1;
                        half_reg <= 8'h00;
                        disp_reg <= KMS_D_HIGH;
                    end else begin
                        half_reg <= half_reg + 8'h01;
                    end
                end
                KMS_D_HIGH: begin
                    if (half_reg == 8'(kms_pkg::DISP_HALF_CYC - 1)) begin
                        disp_clk_reg <= 1'b0;
                        half_reg <= 8'h00;
                        shift_reg <= {shift_reg[DISP_LEN-2:0], 1'b1};
                        bits_left_reg <= bits_left_reg - 11'h001;
                        disp_reg <= (bits_left_reg == 11'h001) ? KMS_D_IDLE : KMS_D_LOW;
                    end else begin
                        half_reg <= half_reg + 8'h01;
                    end
                end
                default: disp_reg <= KMS_D_IDLE;
            endcase
        end
    end

    always_comb begin
        out_port_o = 8'hFF;
        out_port_o[3:0] = col_drive_reg;
        out_port_o[kms_pkg::DISP_CLK_BIT] = disp_clk_reg;
        out_port_o[kms_pkg::DISP_DATA_BIT] = disp_data_reg;
    end

    assign key_event_o = event_reg;
    assign key_any_o = any_reg;
    assign disp_busy_o = (disp_reg != KMS_D_IDLE);
endmodule // kms_host

/* File: hdl/kms_pkg.sv */
package kms_pkg;
    localparam int NUM_ROWS = 6;
    localparam int NUM_COLS = 4;
    localparam int DISP_BITS = 80;
    // host output port bit positions
    localparam int COL_BIT_LO = 0;
    localparam int DISP_CLK_BIT = 6;
    localparam int DISP_DATA_BIT = 7;
    // column drive: low selects, high idles
    localparam logic [3:0] COLS_IDLE = 4'hF;
    localparam logic [3:0] COLS_ALL = 4'h0;
    // display setup time before the rising clock edge
    localparam int DISP_SETUP_NS = 15;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DISP_SETUP_CYC =
        (DISP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // half period of the display clock, at least the setup time
    localparam int DISP_HALF_CYC = DISP_SETUP_CYC;
    // settle time after changing column drive before rows are sampled
    localparam int SETTLE_CYC = 4;

    typedef struct packed {
        logic [5:0] row;
        logic [1:0] col;
    } kms_key_t;

    typedef struct packed {
        logic valid;
        kms_key_t key;
    } kms_key_event_t;
endpackage

/* File: tb/kms_host_sva.sv */
`timescale 1ns/1ps
module kms_host_sva #(
    parameter int DISP_LEN = 80
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] in_port_i,
    input wire logic [7:0] out_port_o,
    input wire kms_pkg::kms_key_event_t key_event_o,
    input wire logic key_any_o,
    input wire logic disp_start_i,
    input wire logic [DISP_LEN-1:0] disp_pattern_i,
    input wire logic disp_busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic [7:0] rises_reg;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !disp_busy_o) rises_reg <= 8'h00;
        else if ($rose(out_port_o[6])) rises_reg <= rises_reg + 8'h01;
    end
    sequence s_rise;
        $rose(out_port_o[6]);
    endsequence
    sequence s_held;
        $stable(out_port_o[7]) && $past(out_port_o[7], 2) == out_port_o[7];
    endsequence
    chk_reset_state: assert property (disable iff (1'b0) reset_i |=>
        out_port_o == 8'hBF && !key_event_o.valid && !key_any_o && !disp_busy_o)
        else $error("reset state wrong");
    chk_one_column: assert property (out_port_o[3:0] == 4'h0 ||
        $onehot(~out_port_o[3:0]) || out_port_o[3:0] == 4'hF) else $error("column drive");
    chk_event_column: assert property (key_event_o.valid |-> key_event_o.key.row < 6 &&
        $past(out_port_o[3:0]) == ~(4'h1 << key_event_o.key.col)) else $error("event column");
    chk_event_row: assert property (key_event_o.valid |->
        ((~$past(in_port_i[5:0], 3) >> key_event_o.key.row) & 6'h01) == 6'h01)
        else $error("event row");
    chk_event_pulse: assert property (key_event_o.valid |=> !key_event_o.valid)
        else $error("event pulse");
    chk_event_any: assert property (key_event_o.valid |-> key_any_o)
        else $error("event without any");
    chk_start_busy: assert property (disp_start_i && !disp_busy_o |=> disp_busy_o)
        else $error("start not taken");
    chk_data_setup: assert property (s_rise |-> s_held) else $error("data setup");
    chk_data_hold: assert property (out_port_o[6] |-> $stable(out_port_o[7]))
        else $error("data hold");
    chk_bit_count: assert property ($fell(disp_busy_o) |-> rises_reg == 8'(DISP_LEN))
        else $error("bit count");
endmodule // kms_host_sva

/* File: tb/kms_matrix_model.sv */
`timescale 1ns/1ps
module kms_matrix_model (
    // host port pins
    input wire logic [7:0] out_port_i,
    output logic [7:0] in_port_o,
    // bench control and display view
    input wire logic [23:0] keys_i,
    output logic [79:0] disp_sr_o
);
    always_comb begin
        // released rows and unused bits sit on pull-ups
        in_port_o = 8'hFF;
        for (int r = 0; r < 6; r++) begin
            for (int c = 0; c < 4; c++) begin
                // diode: only a low column can pull its rows
                if (keys_i[r*4+c] && !out_port_i[c]) in_port_o[r] = 1'b0;
            end
        end
    end
    always_ff @(posedge out_port_i[6]) begin
        disp_sr_o <= {disp_sr_o[78:0], out_port_i[7]};
    end
endmodule // kms_matrix_model

/* File: tb/kms_host_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module kms_host_bench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic disp_start_i = 1'b0;
    logic [79:0] pat = '0;
    logic [23:0] keys = '0;
    logic [7:0] in_port;
    logic [7:0] out_port;
    logic [79:0] disp_sr;
    kms_pkg::kms_key_event_t ev;
    logic any;
    logic busy;
    int err_count = 0;
    int comparisons = 0;
    kms_host i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .in_port_i(in_port),
        .out_port_o(out_port), .key_event_o(ev), .key_any_o(any),
        .disp_start_i(disp_start_i), .disp_pattern_i(pat), .disp_busy_o(busy));
    kms_matrix_model i_far (.out_port_i(out_port), .in_port_o(in_port), .keys_i(keys),
        .disp_sr_o(disp_sr));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    // scan order is column first, then lowest row in that column
    function automatic logic [7:0] exp_key(input logic [23:0] k);
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 6; r++)
                if (k[r*4+c]) return {6'(r), 2'(c)};
        return 8'h00;
    endfunction
    task automatic finish_test;
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic press(input logic [23:0] k);
        int n;
        n = 0;
        @(negedge sys_clk_i);
        keys = k;
        while (ev.valid !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
        end
        `CHK(ev.key, exp_key(k))
        `CHK(any, 1'b1)
        keys = '0;
        while (any !== 1'b0 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        `CHK(any, 1'b0)
    endtask
    task automatic load(input logic [79:0] p);
        int n;
        n = 0;
        pat = p;
        disp_start_i = 1'b1;
        @(negedge sys_clk_i);
        `CHK(busy, 1'b1)
        // a second start while busy must be ignored
        pat = ~p;
        repeat (3) @(negedge sys_clk_i);
        disp_start_i = 1'b0;
        while (busy !== 1'b0 && n < 1000) begin
            @(negedge sys_clk_i);
            n++;
        end
        `CHK(disp_sr, p)
    endtask
    initial begin
        logic [23:0] corners [3];
        corners = '{24'h01_0010, 24'h80_0008, 24'hFF_FFFF};
        void'($urandom(32'he05a_cba5));
        repeat (3) @(negedge sys_clk_i);
        `CHK(out_port, 8'hBF)
        reset_i = 1'b0;
        load(80'({$urandom, $urandom, $urandom}));
        for (int i = 0; i < 24; i++) press(24'h00_0001 << i);
        foreach (corners[i]) press(corners[i]);
        for (int i = 0; i < 20; i++)
            press(24'($urandom & $urandom & $urandom) | (24'h00_0001 << ($urandom % 24)));
        load(80'({$urandom, $urandom, $urandom}));
        finish_test;
    end
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        err_count++;
        finish_test;
    end
endmodule // kms_host_bench
bind kms_host kms_host_sva #(.DISP_LEN(DISP_LEN)) i_sva (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .in_port_i(in_port_i), .out_port_o(out_port_o),
    .key_event_o(key_event_o), .key_any_o(key_any_o), .disp_start_i(disp_start_i),
    .disp_pattern_i(disp_pattern_i), .disp_busy_o(disp_busy_o));
